// ---- design/uart_evt_pkg.sv ----
// Purpose: Shared constants for the serial port event and register block
// Assumes: 32-bit Avalon-MM slave, byte addresses, one register per word
// Notes:   Field positions and codes used by the register and event logic
package uart_evt_pkg;
   // Register byte offsets
   localparam logic [5:0] OFF_DATA   = 6'h00;
   localparam logic [5:0] OFF_IEN    = 6'h04;
   localparam logic [5:0] OFF_IID    = 6'h08;
   localparam logic [5:0] OFF_LCTL   = 6'h0C;
   localparam logic [5:0] OFF_MCTL   = 6'h10;
   localparam logic [5:0] OFF_LSTAT  = 6'h14;
   localparam logic [5:0] OFF_DIVLO  = 6'h20;
   localparam logic [5:0] OFF_DIVHI  = 6'h24;
   localparam logic [5:0] OFF_PID    = 6'h28;
   localparam logic [5:0] OFF_PWREMU = 6'h30;
   localparam logic [5:0] OFF_MODE   = 6'h34;
   // Interrupt enable bits
   localparam int IEN_RX_DATA = 0;
   localparam int IEN_TX_EMPTY = 1;
   localparam int IEN_LINE = 2;
   // Line control and fifo control fields
   localparam int LCTL_DIV_SEL = 7;
   localparam int FCTL_FIFO_EN = 0;
   localparam int FCTL_TRIG_LO = 6;
   // Line status bits
   localparam int LS_READY = 0;
   localparam int LS_OVERRUN = 1;
   localparam int LS_TX_EMPTY = 5;
   localparam int LS_ALL_EMPTY = 6;
   localparam int LS_FIFO_ERR = 7;
   // Power and emulation bits
   localparam int PE_FREE = 0;
   localparam int PE_RX_RUN = 13;
   localparam int PE_TX_RUN = 14;
   // Identification codes; bit 0 high means nothing pending
   localparam logic [3:0] IID_NONE = 4'h1;
   localparam logic [3:0] IID_LINE = 4'h6;
   localparam logic [3:0] IID_RX_DATA = 4'h4;
   localparam logic [3:0] IID_RX_TMO = 4'hC;
   localparam logic [3:0] IID_TX_EMPTY = 4'h2;
   // Receive trigger levels in characters
   localparam logic [4:0] TRIG_1 = 5'h01;
   localparam logic [4:0] TRIG_4 = 5'h04;
   localparam logic [4:0] TRIG_8 = 5'h08;
   localparam logic [4:0] TRIG_14 = 5'h0E;
   // Time-out: four characters of (word bits + 3) bits, 16 ticks a bit
   localparam int TMO_CHARS = 4;
   localparam int TMO_FRAME_EXTRA = 8;
   localparam int TICKS_PER_BIT = 16;
endpackage

// ---- design/baud_gen.sv ----
// Purpose: Baud tick divider with a held-high output until programmed
// Assumes: divisor is stable while the link is busy
// Notes:   tick_q is a one-cycle enable; baud_clk_q is a level
`timescale 1ns/1ps
module baud_gen import uart_evt_pkg::*; #(
   parameter int DIV_W = 16
) (
   // Clock and reset
   input  wire logic             sys_clk,
   input  wire logic             rst_n,
   // Control
   input  wire logic             run,
   input  wire logic             programmed,
   input  wire logic [DIV_W-1:0] divisor,
   // Rates
   output logic                  tick_q,
   output logic                  baud_clk_q
);
   logic [DIV_W-1:0] cnt_q;
   logic             live;
   assign live = programmed && (divisor != '0);

   // Divider; an unprogrammed latch holds the clock at one
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q <= '0;
         tick_q <= 1'b0;
         baud_clk_q <= 1'b1;
      end else if (!live) begin
         cnt_q <= '0;
         tick_q <= 1'b0;
         baud_clk_q <= 1'b1;
      end else if (!run) begin
         tick_q <= 1'b0;
      end else if (cnt_q >= divisor - 1'b1) begin
         cnt_q <= '0;
         tick_q <= 1'b1;
         baud_clk_q <= ~baud_clk_q;
      end else begin
         cnt_q <= cnt_q + 1'b1;
         tick_q <= 1'b0;
      end
   end

   idle_high_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      !programmed |=> baud_clk_q && !tick_q) else $error("baud clock moved");
endmodule

// ---- design/rx_timeout.sv ----
// Purpose: Receive time-out timer over four character times
// Assumes: tick is the 16x baud enable
// Notes:   Fired flag holds until restart or until active drops
`timescale 1ns/1ps
module rx_timeout import uart_evt_pkg::*; (
   // Clock and reset
   input  wire logic       sys_clk,
   input  wire logic       rst_n,
   // Controls
   input  wire logic       tick,
   input  wire logic       active,
   input  wire logic       restart,
   input  wire logic [1:0] word_len,
   // Result
   output logic            fired_q
);
   logic [11:0] cnt_q;
   logic [11:0] limit;
   // Frame bits are word length code + 8, times four characters
   assign limit = 12'(TMO_CHARS * TICKS_PER_BIT * (int'(word_len) + TMO_FRAME_EXTRA));

   // Timer clears on any push, pop or receiver reset
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q <= '0;
         fired_q <= 1'b0;
      end else if (restart || !active) begin
         cnt_q <= '0;
         fired_q <= 1'b0;
      end else if (tick && !fired_q) begin
         cnt_q <= cnt_q + 1'b1;
         if (cnt_q + 1'b1 >= limit) begin
            fired_q <= 1'b1;
         end
      end
   end

   restart_clear_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      restart |=> !fired_q) else $error("time-out survived restart");
endmodule

// ---- design/uart_event_regs.sv ----
// Purpose: Register decode, interrupt arbiter and DMA events of a serial port
// Assumes: serial core on sys_clk supplies fifo levels and error events
// Notes:   One wait state on every access; divisor bytes are not reset
// Behaviour
// - All interrupt sources merge through an arbiter onto one request line.
// - Enabled sources are recorded and forwarded; disabled ones are neither.
// - No new assertion while pending; software rereads the pending bit.
// - Transmit-empty interrupt when holding stage is empty, gated by its enable.
// - Receive-data interrupt on character or fifo trigger, gated by its enable.
// - Data-ready status shows unread characters only, never the trigger.
// - Fifo mode time-out after four idle character times, no status bit.
// - Line-status interrupt on overrun, parity, framing or break.
// - No DMA request at all unless fifo mode is enabled.
// - Receive DMA request on trigger level reached or time-out.
// - Receive DMA request withheld while head character is erroneous.
// - Transmit DMA request when the transmit fifo becomes empty.
// - Transmit DMA request when transmitter leaves software reset.
// - Suspend without free-run stops after current word; free-run keeps going.
// - Register access keeps working during emulation suspend.
// - Divisor is not reset; unprogrammed baud clock stays at one.
// - Offset 0 is data, or divisor low byte when selected; also at 20h.
// - Offset 4 is enable, or divisor high byte when selected; also at 24h.
// - Offset 8 reads identification and writes fifo control always.
// - Character time is start, data, parity and stop bits.
// - Time-out and timer clear on pop, new character or receiver reset.
// - Priority is line status, then receive data or time-out, then empty.
`timescale 1ns/1ps
module uart_event_regs import uart_evt_pkg::*; #(
   parameter int          CNT_W  = 5,
   parameter logic [31:0] ID_VAL = 32'h0000_0001 // Arbitrary value
) (
   // Clock and reset
   input  wire logic             sys_clk,
   input  wire logic             rst_n,
   // Avalon-MM slave
   input  wire logic [5:0]       avs_address,
   input  wire logic             avs_read,
   input  wire logic             avs_write,
   input  wire logic [31:0]      avs_writedata,
   output logic [31:0]           avs_readdata,
   output logic                  avs_waitrequest,
   // Receive path status
   input  wire logic [CNT_W-1:0] rx_count,
   input  wire logic [7:0]       rx_head_data,
   input  wire logic             rx_head_err,
   input  wire logic             rx_err_any,
   input  wire logic             rx_char_push,
   input  wire logic [3:0]       line_err_evt,
   // Transmit path status
   input  wire logic             tx_fifo_empty,
   input  wire logic             tx_shifter_empty,
   input  wire logic             tx_busy,
   input  wire logic             emu_suspend,
   // Requests
   output logic                  uart_irq,
   output logic                  rx_dma_req,
   output logic                  tx_dma_req,
   // Serial core controls
   output logic                  rx_pop,
   output logic                  tx_push,
   output logic [7:0]            tx_data,
   output logic                  fifo_en,
   output logic [1:0]            word_length_sel,
   output logic                  rx_reset_n,
   output logic                  tx_reset_n,
   output logic                  serial_halt,
   output logic                  baud_tick,
   output logic                  baud_clk
);
   ////////////////////////////////////////////////////////////////////
   logic        wait_q;
   logic [31:0] rdata_q;
   logic [31:0] rdata_d;
   logic        rd_cap;
   logic        wr_acc;
   logic [2:0]  ien_q;
   logic [7:0]  fctl_q;
   logic [7:0]  lctl_q;
   logic [4:0]  mctl_q;
   logic [15:0] pwremu_q;
   logic        mode_q;
   logic [7:0]  div_lo_q;
   logic [7:0]  div_hi_q;
   logic        div_prog_q;
   logic [3:0]  line_err_q;
   logic        irq_q;
   logic        rx_dma_q;
   logic        tx_dma_q;
   logic        rx_evt_q;
   logic        tx_empty_prev_q;
   logic        tx_run_prev_q;
   logic        pop_q;
   logic        push_q;
   logic [7:0]  tx_data_q;
   logic        halt_q;
   logic        halt_d;
   logic        rto_q;
   logic        div_sel;
   logic        rd_pop;
   logic        line_src;
   logic        rda_src;
   logic        rto_src;
   logic        thr_src;
   logic        any_src;
   logic [3:0]  iid_code;
   logic [4:0]  trig_lvl;
   logic        rda_cond;
   logic        rx_evt;
   logic        tx_rst_rel;

   // Read seen on a wait cycle is captured; a write is taken on the next edge, which completes it
   assign rd_cap = avs_read && wait_q;
   assign wr_acc = avs_write && !wait_q;
   assign div_sel = lctl_q[LCTL_DIV_SEL];
   assign rd_pop = rd_cap && (avs_address == OFF_DATA) && !div_sel;

   ////////////////////////////////////////////////////////////////////
   // Bus handshake runs independent of suspend or halt state
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         wait_q <= 1'b1;
      end else begin
         wait_q <= !((avs_read || avs_write) && wait_q);
      end
   end

   // Read data captured with the side effects of the read
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata_q <= '0;
      end else if (rd_cap) begin
         rdata_q <= rdata_d;
      end
   end

   // Read decode; unmapped offsets read as zero
   always_comb begin
      rdata_d = '0;
      if (avs_address == OFF_DATA) begin
         rdata_d = div_sel ? 32'(div_lo_q) : 32'(rx_head_data);
      end else if (avs_address == OFF_IEN) begin
         rdata_d = div_sel ? 32'(div_hi_q) : 32'(ien_q);
      end else if (avs_address == OFF_IID) begin
         rdata_d = {24'h0, {2{fctl_q[FCTL_FIFO_EN]}}, 2'h0, iid_code};
      end else if (avs_address == OFF_LCTL) begin
         rdata_d = 32'(lctl_q);
      end else if (avs_address == OFF_MCTL) begin
         rdata_d = 32'(mctl_q);
      end else if (avs_address == OFF_LSTAT) begin
         rdata_d[LS_READY] = (rx_count != '0);
         rdata_d[LS_OVERRUN+3:LS_OVERRUN] = line_err_q;
         rdata_d[LS_TX_EMPTY] = tx_fifo_empty;
         rdata_d[LS_ALL_EMPTY] = tx_fifo_empty && tx_shifter_empty;
         rdata_d[LS_FIFO_ERR] = rx_err_any;
      end else if (avs_address == OFF_DIVLO) begin
         rdata_d = 32'(div_lo_q);
      end else if (avs_address == OFF_DIVHI) begin
         rdata_d = 32'(div_hi_q);
      end else if (avs_address == OFF_PID) begin
         rdata_d = ID_VAL;
      end else if (avs_address == OFF_PWREMU) begin
         rdata_d = 32'(pwremu_q);
      end else if (avs_address == OFF_MODE) begin
         rdata_d = 32'(mode_q);
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Control registers written on the accepting edge
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         ien_q <= '0;
         fctl_q <= '0;
         lctl_q <= '0;
         mctl_q <= '0;
         pwremu_q <= '0;
         mode_q <= 1'b0;
      end else if (wr_acc) begin
         if (avs_address == OFF_IEN && !div_sel) begin
            ien_q <= avs_writedata[2:0];
         end else if (avs_address == OFF_IID) begin
            fctl_q <= avs_writedata[7:0];
         end else if (avs_address == OFF_LCTL) begin
            lctl_q <= avs_writedata[7:0];
         end else if (avs_address == OFF_MCTL) begin
            mctl_q <= avs_writedata[4:0];
         end else if (avs_address == OFF_PWREMU) begin
            pwremu_q <= avs_writedata[15:0];
         end else if (avs_address == OFF_MODE) begin
            mode_q <= avs_writedata[0];
         end
      end
   end

   // Divisor bytes deliberately keep their value through reset
   always_ff @(posedge sys_clk) begin
      if (wr_acc && (avs_address == OFF_DIVLO ||
                     (avs_address == OFF_DATA && div_sel))) begin
         div_lo_q <= avs_writedata[7:0];
      end
      if (wr_acc && (avs_address == OFF_DIVHI ||
                     (avs_address == OFF_IEN && div_sel))) begin
         div_hi_q <= avs_writedata[7:0];
      end
   end

   // Baud output stays high until software loads a divisor byte
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         div_prog_q <= 1'b0;
      end else if (wr_acc && (avs_address == OFF_DIVLO || avs_address == OFF_DIVHI ||
                              ((avs_address == OFF_DATA || avs_address == OFF_IEN)
                               && div_sel))) begin
         div_prog_q <= 1'b1;
      end
   end

   // Data strobes to the serial core
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         pop_q <= 1'b0;
         push_q <= 1'b0;
         tx_data_q <= '0;
      end else begin
         pop_q <= rd_pop;
         push_q <= wr_acc && (avs_address == OFF_DATA) && !div_sel;
         if (wr_acc && (avs_address == OFF_DATA) && !div_sel) begin
            tx_data_q <= avs_writedata[7:0];
         end
      end
   end

   // Sticky line errors cleared by a status read; a new error wins
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         line_err_q <= '0;
      end else begin
         line_err_q <= (rd_cap && avs_address == OFF_LSTAT) ?
                       line_err_evt : (line_err_q | line_err_evt);
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Suspend: finish the current word, then stop until released
   assign halt_d = emu_suspend && !pwremu_q[PE_FREE] && (halt_q || !tx_busy);

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         halt_q <= 1'b0;
      end else begin
         halt_q <= halt_d;
      end
   end

   baud_gen #(
      .DIV_W(16)
   ) u_baud (
      .sys_clk   (sys_clk),
      .rst_n     (rst_n),
      .run       (!halt_q),
      .programmed(div_prog_q),
      .divisor   ({div_hi_q, div_lo_q}),
      .tick_q    (baud_tick),
      .baud_clk_q(baud_clk)
   );

   // Timer only runs in fifo mode with data held and receiver active
   rx_timeout u_tmo (
      .sys_clk (sys_clk),
      .rst_n   (rst_n),
      .tick    (baud_tick),
      .active  (fctl_q[FCTL_FIFO_EN] && rx_count != '0 && pwremu_q[PE_RX_RUN]),
      .restart (rx_char_push || rd_pop || !pwremu_q[PE_RX_RUN]),
      .word_len(lctl_q[1:0]),
      .fired_q (rto_q)
   );

   ////////////////////////////////////////////////////////////////////
   // Trigger level selection; trade-off: decode kept combinational
   always_comb begin
      case (fctl_q[FCTL_TRIG_LO+1:FCTL_TRIG_LO])
         2'd0: trig_lvl = TRIG_1;
         2'd1: trig_lvl = TRIG_4;
         2'd2: trig_lvl = TRIG_8;
         default: trig_lvl = TRIG_14;
      endcase
   end

   // Masked sources; disabled ones never reach the code or the line
   assign rda_cond = fctl_q[FCTL_FIFO_EN] ? (5'(rx_count) >= trig_lvl) :
                     (rx_count != '0);
   assign line_src = ien_q[IEN_LINE] && (line_err_q != '0);
   assign rda_src = ien_q[IEN_RX_DATA] && rda_cond;
   assign rto_src = ien_q[IEN_RX_DATA] && rto_q;
   assign thr_src = ien_q[IEN_TX_EMPTY] && tx_fifo_empty;
   assign any_src = line_src || rda_src || rto_src || thr_src;

   // Arbiter picks one code in fixed priority
   always_comb begin
      if (line_src) begin
         iid_code = IID_LINE;
      end else if (rda_src) begin
         iid_code = IID_RX_DATA;
      end else if (rto_src) begin
         iid_code = IID_RX_TMO;
      end else if (thr_src) begin
         iid_code = IID_TX_EMPTY;
      end else begin
         iid_code = IID_NONE;
      end
   end

   // One level line; more sources do not pulse it again
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= any_src;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Receive event, held back by an erroneous head character
   assign rx_evt = fctl_q[FCTL_FIFO_EN] && !rx_head_err &&
                   ((5'(rx_count) >= trig_lvl) || rto_q);
   // Release of transmitter software reset
   assign tx_rst_rel = pwremu_q[PE_TX_RUN] && !tx_run_prev_q;

   // Events are one-cycle pulses on each new occurrence
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         rx_evt_q <= 1'b0;
         tx_empty_prev_q <= 1'b0;
         tx_run_prev_q <= 1'b0;
         rx_dma_q <= 1'b0;
         tx_dma_q <= 1'b0;
      end else begin
         rx_evt_q <= rx_evt;
         tx_empty_prev_q <= tx_fifo_empty;
         tx_run_prev_q <= pwremu_q[PE_TX_RUN];
         rx_dma_q <= rx_evt && !rx_evt_q;
         tx_dma_q <= fctl_q[FCTL_FIFO_EN] && ((tx_fifo_empty && !tx_empty_prev_q)
                     || tx_rst_rel);
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Outputs straight from flip-flops
   assign avs_readdata = rdata_q;
   assign avs_waitrequest = wait_q;
   assign uart_irq = irq_q;
   assign rx_dma_req = rx_dma_q;
   assign tx_dma_req = tx_dma_q;
   assign rx_pop = pop_q;
   assign tx_push = push_q;
   assign tx_data = tx_data_q;
   assign fifo_en = fctl_q[FCTL_FIFO_EN];
   assign word_length_sel = lctl_q[1:0];
   assign rx_reset_n = pwremu_q[PE_RX_RUN];
   assign tx_reset_n = pwremu_q[PE_TX_RUN];
   assign serial_halt = halt_q;

   ////////////////////////////////////////////////////////////////////
   irq_follow_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      any_src |=> uart_irq) else $error("irq missing");
   irq_drop_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      !any_src |=> !uart_irq) else $error("irq stuck");
   dma_nofifo_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      !fifo_en ##1 !fifo_en |-> !rx_dma_req && !tx_dma_req)
      else $error("dma outside fifo mode");
   rx_dma_err_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      rx_head_err |=> !rx_dma_req) else $error("dma on bad head");
   rx_dma_trig_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      $rose(rx_evt) |=> rx_dma_req) else $error("rx event lost");
   tx_dma_empty_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      fifo_en && $rose(tx_fifo_empty) |=> tx_dma_req)
      else $error("tx empty event lost");
   tx_dma_rst_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      fifo_en && $rose(tx_reset_n) |=> tx_dma_req)
      else $error("tx reset release event lost");
   ready_bit_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      rd_cap && avs_address == OFF_LSTAT |=>
      avs_readdata[LS_READY] == ($past(rx_count) != '0))
      else $error("data ready wrong");
   iid_none_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      rd_cap && avs_address == OFF_IID && !any_src |=> avs_readdata[0])
      else $error("pending shown with no source");
   line_first_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      rd_cap && avs_address == OFF_IID && line_src |=> avs_readdata[3:0] == IID_LINE)
      else $error("priority wrong");
   halt_stop_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      emu_suspend && !pwremu_q[PE_FREE] && !tx_busy |=> serial_halt)
      else $error("no halt on suspend");
   free_run_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      pwremu_q[PE_FREE] |=> !serial_halt) else $error("halt in free run");
   bus_suspend_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      emu_suspend && (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
      else $error("bus stalled in suspend");
endmodule

// ---- test/core_model.sv ----
// Purpose: Serial core stand-in feeding fifo levels
// Assumes: bench asks for characters and drains
// Notes:   Head error shows only while data waits
`timescale 1ns/1ps
module core_model (
   // Clock, reset, bench requests
   input  wire logic       sys_clk, rst_n, add, bad, txe,
   // Block controls
   input  wire logic       rx_pop, tx_push,
   // Status towards the block
   output logic [4:0]      rx_count,
   output logic [7:0]      rx_head_data,
   output logic            rx_char_push, tx_fifo_empty,
   output logic            rx_head_err, rx_err_any, tx_shifter_empty, tx_busy
);
   ////////////////////////////////////////////////////////////////////////
   // Level moves one character per request or pop
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         rx_count <= 5'h00;
         rx_char_push <= 1'b0;
         tx_fifo_empty <= 1'b0;
      end else begin
         rx_count <= rx_count + 5'(add) - 5'(rx_pop && rx_count != 5'h00);
         rx_char_push <= add;
         tx_fifo_empty <= txe | (tx_fifo_empty & ~tx_push); // Last byte left
      end
   end
   // Head byte follows the level so reads differ
   assign rx_head_data = 8'hA0 | 8'(rx_count);
   assign rx_head_err = bad && rx_count != 5'h00;
   assign rx_err_any = rx_head_err;
   assign tx_shifter_empty = tx_fifo_empty;
   assign tx_busy = ~tx_fifo_empty;
endmodule

// ---- test/tb_uart_event_regs.sv ----
// Purpose: Self-checking bench for the event and register block
// Assumes: one wait state per access
// Notes:   Event pulses are counted, not sampled
`timescale 1ns/1ps
module tb_uart_event_regs import uart_evt_pkg::*;;
   logic sys_clk = 0, rst_n = 0, avs_read = 0, avs_write = 0, emu_suspend = 0;
   logic add = 0, bad = 0, txe = 0, avs_waitrequest, uart_irq, rx_dma_req, tx_dma_req;
   logic rx_pop, tx_push, fifo_en, rx_head_err, rx_err_any, rx_char_push, tx_busy;
   logic tx_fifo_empty, tx_shifter_empty, rx_reset_n, tx_reset_n, serial_halt;
   logic baud_tick, baud_clk;
   logic [5:0]  avs_address = 6'h00;
   logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
   logic [3:0]  line_err_evt = 4'h0;
   logic [4:0]  rx_count;
   logic [7:0]  rx_head_data, tx_data;
   logic [1:0]  word_length_sel;
   int          miscompares = 0, checks_done = 0, cycles = 0, rx_hits = 0, tx_hits = 0, n;
   uart_event_regs uart_event_regs_i (.*);
   core_model      core_model_i (.*);
   ////////////////////////////////////////////////////////////////////////
   always #12.5 sys_clk = ~sys_clk;
   // Pulse counters and hang guard; a pulse stands one cycle only
   always @(posedge sys_clk) begin
      cycles <= cycles + 1;
      rx_hits <= rx_hits + int'(rx_dma_req === 1'b1); // Counted from reset on; the channel stays quiet until fifo mode is on
      tx_hits <= tx_hits + int'(tx_dma_req === 1'b1);
      if (cycles == 20000) begin
         miscompares++;
         wrap_up();
      end
   end
   task automatic chk(input string what, input logic [31:0] exp, got);
      checks_done++;
      if (got !== exp) begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic tick(input int k);
      repeat (k) @(posedge sys_clk);
   endtask
   // Request held until waitrequest is sampled low
   task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
      avs_address <= a;
      avs_write <= wr;
      avs_read <= ~wr;
      avs_writedata <= d;
      do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      @(posedge sys_clk);
   endtask
   ////////////////////////////////////////////////////////////////////////
   task automatic t_decode;
      chk("baud idle", 1, baud_clk);
      bus(1, OFF_LCTL, 32'h80); // Divisor set first, link still idle
      bus(1, OFF_DATA, 32'h5A);
      bus(0, OFF_DIVLO, 0); chk("div low", 32'h5A, q);
      bus(1, OFF_DIVHI, 32'h3C);
      bus(0, OFF_IEN, 0); chk("div high", 32'h3C, q);
      bus(0, OFF_IID, 0); chk("iid sel", IID_NONE, q[3:0]);
      bus(1, OFF_LCTL, 32'h03); chk("word len", 3, word_length_sel);
      bus(1, OFF_IEN, 32'h5);
      bus(0, OFF_IEN, 0); chk("enable", 32'h5, q);
      bus(0, 6'h3C, 0); chk("unmapped", 0, q);
      $display("test decode done");
   endtask
   task automatic t_irq;
      txe <= 1'b1; tick(1); txe <= 1'b0; tick(3);
      chk("irq masked", 0, uart_irq);
      bus(0, OFF_IID, 0); chk("iid masked", IID_NONE, q[3:0]);
      bus(1, OFF_IEN, 32'h6); tick(3);
      chk("irq tx", 1, uart_irq);
      bus(0, OFF_IID, 0); chk("iid tx", IID_TX_EMPTY, q[3:0]);
      line_err_evt <= 4'h1; tick(1); line_err_evt <= 4'h0; tick(3);
      bus(0, OFF_IID, 0); chk("iid line", IID_LINE, q[3:0]);
      chk("irq one", 1, uart_irq);
      bus(0, OFF_LSTAT, 0); chk("overrun", 1, q[LS_OVERRUN]);
      bus(0, OFF_IID, 0); chk("iid rest", IID_TX_EMPTY, q[3:0]);
      bus(1, OFF_DATA, 32'h11); chk("tx data", 32'h11, tx_data); tick(4);
      chk("irq none", 0, uart_irq);
      bus(0, OFF_IID, 0); chk("iid none", IID_NONE, q[3:0]);
      $display("test interrupt done");
   endtask
   task automatic t_dma;
      n = rx_hits;
      add <= 1'b1; tick(1); add <= 1'b0; tick(4);
      chk("no dma", n, rx_hits);
      bus(0, OFF_DATA, 0); chk("head", 32'hA1, q);
      bus(1, OFF_IID, 32'h41); chk("fifo on", 1, fifo_en);
      add <= 1'b1; tick(1); add <= 1'b0; tick(4);
      chk("below trig", n, rx_hits);
      bus(0, OFF_LSTAT, 0); chk("ready", 1, q[LS_READY]);
      add <= 1'b1; tick(3); add <= 1'b0; tick(4);
      chk("at trig", n + 1, rx_hits);
      bus(1, OFF_IEN, 32'h7); bus(0, OFF_IID, 0);
      chk("iid rx", IID_RX_DATA, q[3:0]);
      repeat (4) bus(0, OFF_DATA, 0);
      bad <= 1'b1; add <= 1'b1; tick(4); add <= 1'b0; tick(4);
      chk("head err", n + 1, rx_hits);
      n = tx_hits;
      txe <= 1'b1; tick(1); txe <= 1'b0; tick(3);
      chk("tx dma", n + 1, tx_hits);
      bus(1, OFF_PWREMU, 32'h6000); tick(3);
      chk("tx release", n + 2, tx_hits);
      chk("run bits", 2'h3, {rx_reset_n, tx_reset_n});
      emu_suspend <= 1'b1; tick(3);
      chk("halt", 1, serial_halt);
      bus(0, OFF_IEN, 0); chk("ien suspend", 32'h7, q);
      bus(1, OFF_PWREMU, 32'h6001); tick(1);
      chk("free run", 0, serial_halt);
      $display("test dma done");
   endtask
   // Mid-run reset keeps the divisor; then a time-out of four 8-bit frames at 16 ticks
   task automatic t_reset;
      rst_n <= 1'b0; bad <= 1'b0; emu_suspend <= 1'b0; tick(2);
      rst_n <= 1'b1; tick(1);
      bus(0, OFF_DIVLO, 0); chk("div kept", 32'h5A, q);
      chk("baud held", 1, baud_clk);
      bus(1, OFF_DIVLO, 32'h1); bus(1, OFF_DIVHI, 32'h0); // Fast ticks after reset
      bus(1, OFF_IID, 32'hC1); bus(1, OFF_PWREMU, 32'h2000); bus(1, OFF_IEN, 32'h1);
      chk("tick run", 1, baud_tick);
      n = rx_hits;
      add <= 1'b1; tick(1); add <= 1'b0; tick(500);
      chk("tmo early", 0, uart_irq);
      tick(40);
      chk("tmo irq", 1, uart_irq);
      bus(0, OFF_IID, 0); chk("iid tmo", IID_RX_TMO, q[3:0]);
      chk("tmo dma", n + 1, rx_hits);
      bus(0, OFF_DATA, 0); chk("tmo clear", 0, uart_irq);
      $display("test reset done");
   endtask
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // Reset for 16 cycles, then the tests in order
   initial begin
      tick(16);
      rst_n <= 1'b1;
      t_decode();
      t_irq();
      t_dma();
      t_reset();
      wrap_up();
   end
endmodule
